/* src/rac_defines.svh */
// constants of the region access checker
// Summary of operation
// [R1] Sixteen region descriptors define regions and rights for every checked transfer.
// [R2] Each region has start and end address at 32-byte granule, up to 4 GB.
// [R3] After reset the checker is disabled and lets every transfer through.
// [R4] Core master has supervisor and user read/write/execute; others only read/write.
// [R5] Hardware clears a descriptor's valid bit while it is rewritten.
// [R6] An alternate write path changes only the access control word.
// [R7] Overlapping regions: any granting region allows the access.
// [R8] Both guarded ports, memory and peripheral bridge, are checked.
// [R9] Error when address hits no valid region or is denied in all hits.
// [R10] Faulting transfer gets an error response and never reaches the slave.
// [R11] Permitted transfers pass to the slave without error signalling.
// [R12] Each port keeps a 64-bit record of its latest faulting transfer.
// [R13] Each new error overwrites the record and sets a clearable port flag.
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

`define RAC_REGIONS 16
`define RAC_PORTS 2
`define RAC_GRAN_LSB 5
`define RAC_GRAN_MASK 5'h1f
`define RAC_ADDR_MSB 31
`define RAC_GRAN_RST 27'h0000000
`define RAC_ACW_MSB 11
`define RAC_ACW_LSB 0
`define RAC_VALID_BIT 0
`define RAC_REC_PAD 9'h000

// configuration word selects
`define RAC_SEL_START 3'h0
`define RAC_SEL_END 3'h1
`define RAC_SEL_ACW 3'h2
`define RAC_SEL_VALID 3'h3
`define RAC_SEL_ACW_ALT 3'h4

// access control word fields
`define RAC_ACW_SUP_R 0
`define RAC_ACW_SUP_W 1
`define RAC_ACW_SUP_X 2
`define RAC_ACW_USR_R 3
`define RAC_ACW_USR_W 4
`define RAC_ACW_USR_X 5
`define RAC_ACW_M1_R 6
`define RAC_ACW_M1_W 7
`define RAC_ACW_M2_R 8
`define RAC_ACW_M2_W 9
`define RAC_ACW_M3_R 10
`define RAC_ACW_M3_W 11
`define RAC_ACW_RST 12'h000

// master numbers
`define RAC_MASTER_CORE 4'h0
`define RAC_MASTER_1 4'h1
`define RAC_MASTER_2 4'h2
`define RAC_MASTER_3 4'h3

`endif

/* src/rac_pkg.sv */
// types shared by the region access checker files
`default_nettype none
`include "rac_defines.svh"
package rac_pkg;
   typedef struct packed {
      logic [26:0] start_gran; // start address bits 31:5
      logic [26:0] end_gran;   // last granule, inclusive
      logic [11:0] acw;        // access control word
      logic valid;
   } descriptor_t;

   typedef struct packed {
      logic s_valid;
      logic [31:0] s_addr;
      logic s_write;
      logic err;
      logic flag;
      logic [63:0] record;
   } port_state_t;

   typedef struct packed {
      logic enable;
      descriptor_t [`RAC_REGIONS-1:0] desc;
      port_state_t [`RAC_PORTS-1:0] port;
   } state_t;
endpackage
`default_nettype wire

/* src/region_match.sv */
// combinational region lookup for one guarded port
`default_nettype none
`include "rac_defines.svh"
module region_match #(
   parameter int NUM_REGIONS = `RAC_REGIONS
) (
   input wire rac_pkg::descriptor_t [NUM_REGIONS-1:0] desc_i, // descriptors
   input wire logic [31:0] addr_i,         // transfer address
   input wire logic write_i,               // 1 write, 0 read
   input wire logic exec_i,                // instruction fetch
   input wire logic super_i,               // supervisor mode
   input wire logic [3:0] master_i,        // master number
   output logic [NUM_REGIONS-1:0] hit_o,   // valid regions hit
   output logic grant_o                    // some hit region grants
);
   // rights of one descriptor for the request
   function automatic logic perm_ok(input logic [11:0] acw, input logic wr,
                                    input logic ex, input logic sup,
                                    input logic [3:0] m);
      logic ok;
      ok = 1'b0;
      case (m)
         `RAC_MASTER_CORE: begin // R4
            if (sup) begin
               ok = ex ? acw[`RAC_ACW_SUP_X] : (wr ? acw[`RAC_ACW_SUP_W] : acw[`RAC_ACW_SUP_R]);
            end else begin
               ok = ex ? acw[`RAC_ACW_USR_X] : (wr ? acw[`RAC_ACW_USR_W] : acw[`RAC_ACW_USR_R]);
            end
         end
         // non-core fetches are judged as reads: they carry no execute right
         `RAC_MASTER_1: ok = wr ? acw[`RAC_ACW_M1_W] : acw[`RAC_ACW_M1_R]; // R4
         `RAC_MASTER_2: ok = wr ? acw[`RAC_ACW_M2_W] : acw[`RAC_ACW_M2_R]; // R4
         `RAC_MASTER_3: ok = wr ? acw[`RAC_ACW_M3_W] : acw[`RAC_ACW_M3_R]; // R4
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // any hit with sufficient rights grants, denials never override
   always_comb begin
      grant_o = 1'b0;
      for (int r = 0; r < NUM_REGIONS; r++) begin
         hit_o[r] = desc_i[r].valid
                    && (addr_i[`RAC_ADDR_MSB:`RAC_GRAN_LSB] >= desc_i[r].start_gran)
                    && (addr_i[`RAC_ADDR_MSB:`RAC_GRAN_LSB] <= desc_i[r].end_gran); // R2
         if (hit_o[r] && perm_ok(desc_i[r].acw, write_i, exec_i, super_i, master_i)) begin
            grant_o = 1'b1; // R7
         end
      end
   end
endmodule
`default_nettype wire

/* src/region_access_checker.sv */
// region access checker guarding the memory and peripheral bridge ports
`default_nettype none
`include "rac_defines.svh"
module region_access_checker (
   input wire logic ref_clk_i,                      // system clock
   input wire logic reset_i,                        // async reset, high
   // enable control
   input wire logic enable_wr_i,                    // load enable bit
   input wire logic enable_i,                       // new enable value
   // descriptor programming
   input wire logic cfg_wr_i,                       // descriptor word write
   input wire logic [3:0] cfg_region_i,             // descriptor number
   input wire logic [2:0] cfg_sel_i,                // word select
   input wire logic [31:0] cfg_data_i,              // write data
   // crossbar side, index 0 memory, 1 peripheral bridge
   input wire logic [`RAC_PORTS-1:0] m_valid_i,     // transfer request
   input wire logic [`RAC_PORTS-1:0][31:0] m_addr_i, // address
   input wire logic [`RAC_PORTS-1:0] m_write_i,     // write transfer
   input wire logic [`RAC_PORTS-1:0] m_exec_i,      // instruction fetch
   input wire logic [`RAC_PORTS-1:0] m_super_i,     // supervisor mode
   input wire logic [`RAC_PORTS-1:0][3:0] m_master_i, // master number
   output logic [`RAC_PORTS-1:0] m_err_o,           // error response pulse
   // guarded slave side
   output logic [`RAC_PORTS-1:0] s_valid_o,         // forwarded request
   output logic [`RAC_PORTS-1:0][31:0] s_addr_o,    // forwarded address
   output logic [`RAC_PORTS-1:0] s_write_o,         // forwarded direction
   // error records
   input wire logic [`RAC_PORTS-1:0] err_clear_i,   // clear error flag
   output logic [`RAC_PORTS-1:0] err_flag_o,        // error recorded
   output logic [`RAC_PORTS-1:0][63:0] err_record_o, // last fault
   output logic enabled_o                           // checker enforcing
);
   rac_pkg::state_t st;
   rac_pkg::state_t next_st;
   logic [`RAC_PORTS-1:0][`RAC_REGIONS-1:0] hit;
   logic [`RAC_PORTS-1:0] grant;
   rac_pkg::descriptor_t [`RAC_REGIONS-1:0] desc_view;

   // error record layout: address, hit map, attributes
   function automatic logic [63:0] fault_record(input logic [31:0] addr,
                                                input logic [15:0] hits,
                                                input logic [3:0] master,
                                                input logic wr, input logic ex,
                                                input logic sup);
      return {addr, hits, `RAC_REC_PAD, master, sup, ex, wr};
   endfunction

   assign desc_view = st.desc;

   // one lookup per guarded port
   for (genvar p = 0; p < `RAC_PORTS; p++) begin : g_port
      region_match #(
         .NUM_REGIONS(`RAC_REGIONS)
      ) u_match (
         .desc_i(desc_view),
         .addr_i(m_addr_i[p]),
         .write_i(m_write_i[p]),
         .exec_i(m_exec_i[p]),
         .super_i(m_super_i[p]),
         .master_i(m_master_i[p]),
         .hit_o(hit[p]),
         .grant_o(grant[p])
      ); // R8
   end

   // next state: transfer judgement, records and programming
   always_comb begin
      next_st = st;
      for (int p = 0; p < `RAC_PORTS; p++) begin
         next_st.port[p].s_valid = 1'b0;
         next_st.port[p].err = 1'b0;
         // clear first so that a same-cycle fault wins
         if (err_clear_i[p]) begin
            next_st.port[p].flag = 1'b0; // R13
         end
         if (m_valid_i[p]) begin
            if (!st.enable || grant[p]) begin
               next_st.port[p].s_valid = 1'b1; // R3 R11
               next_st.port[p].s_addr = m_addr_i[p];
               next_st.port[p].s_write = m_write_i[p];
            end else begin
               // no hit or denied everywhere: slave never sees it
               next_st.port[p].err = 1'b1; // R9 R10
               next_st.port[p].flag = 1'b1; // R13
               next_st.port[p].record = fault_record(m_addr_i[p], hit[p], m_master_i[p],
                                                    m_write_i[p], m_exec_i[p],
                                                    m_super_i[p]); // R12
            end
         end
      end
      if (enable_wr_i) begin
         next_st.enable = enable_i;
      end
      if (cfg_wr_i) begin
         case (cfg_sel_i)
            `RAC_SEL_START: begin
               // region is pulled out of use until its valid word is rewritten
               next_st.desc[cfg_region_i].start_gran =
                  cfg_data_i[`RAC_ADDR_MSB:`RAC_GRAN_LSB]; // R2
               next_st.desc[cfg_region_i].valid = 1'b0; // R5
            end
            `RAC_SEL_END: begin
               next_st.desc[cfg_region_i].end_gran =
                  cfg_data_i[`RAC_ADDR_MSB:`RAC_GRAN_LSB]; // R2
               next_st.desc[cfg_region_i].valid = 1'b0; // R5
            end
            `RAC_SEL_ACW: begin
               next_st.desc[cfg_region_i].acw = cfg_data_i[`RAC_ACW_MSB:`RAC_ACW_LSB];
               next_st.desc[cfg_region_i].valid = 1'b0; // R5
            end
            `RAC_SEL_VALID: begin
               next_st.desc[cfg_region_i].valid = cfg_data_i[`RAC_VALID_BIT]; // R5
            end
            `RAC_SEL_ACW_ALT: begin
               // rights only, bounds and valid bit stay as they are
               next_st.desc[cfg_region_i].acw =
                  cfg_data_i[`RAC_ACW_MSB:`RAC_ACW_LSB]; // R6
            end
            default: begin
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st.enable <= 1'b0; // R3
         for (int r = 0; r < `RAC_REGIONS; r++) begin
            st.desc[r].start_gran <= `RAC_GRAN_RST;
            st.desc[r].end_gran <= `RAC_GRAN_RST;
            st.desc[r].acw <= `RAC_ACW_RST;
            st.desc[r].valid <= 1'b0; // R1
         end
         for (int p = 0; p < `RAC_PORTS; p++) begin
            st.port[p].s_valid <= 1'b0;
            st.port[p].s_addr <= 32'h00000000;
            st.port[p].s_write <= 1'b0;
            st.port[p].err <= 1'b0;
            st.port[p].flag <= 1'b0;
            st.port[p].record <= 64'h0000000000000000;
         end
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   always_comb begin
      for (int p = 0; p < `RAC_PORTS; p++) begin
         m_err_o[p] = st.port[p].err;
         s_valid_o[p] = st.port[p].s_valid;
         s_addr_o[p] = st.port[p].s_addr;
         s_write_o[p] = st.port[p].s_write;
         err_flag_o[p] = st.port[p].flag;
         err_record_o[p] = st.port[p].record;
      end
   end
   assign enabled_o = st.enable;
endmodule
`default_nettype wire

/* verification/rac_props.sv */
// assertions on the region access checker ports
`default_nettype none
module rac_props (
   input wire logic ref_clk_i, // clock
   input wire logic reset_i, // reset
   input wire logic [1:0] m_valid_i, // request
   input wire logic [1:0][31:0] m_addr_i, // address
   input wire logic [1:0] m_write_i, // write
   input wire logic [1:0] m_exec_i, // fetch
   input wire logic [1:0] m_super_i, // mode
   input wire logic [1:0][3:0] m_master_i, // master
   input wire logic [1:0] err_clear_i, // clear
   input wire logic [1:0] m_err_o, // error
   input wire logic [1:0] s_valid_o, // forward
   input wire logic [1:0][31:0] s_addr_o, // fwd addr
   input wire logic [1:0] s_write_o, // fwd dir
   input wire logic [1:0] err_flag_o, // flag
   input wire logic [1:0][63:0] err_record_o, // record
   input wire logic enabled_o // enforcing
);
   timeunit 1ns;
   timeprecision 1ps;
   // one clock domain, reset drops every attempt in flight
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // request followed by forward or by error on the memory port
   sequence s_fwd; m_valid_i[0] ##1 s_valid_o[0]; endsequence
   sequence s_bad; m_valid_i[0] ##1 m_err_o[0]; endsequence
   AST_ANSWER0: assert property (m_valid_i[0] |=> s_valid_o[0] != m_err_o[0])
      else $error("memory port answer wrong");
   AST_ANSWER1: assert property (m_valid_i[1] |=> s_valid_o[1] != m_err_o[1])
      else $error("bridge port answer wrong");
   AST_IDLE: assert property (!m_valid_i[0] |=> !s_valid_o[0] && !m_err_o[0])
      else $error("answer without request");
   AST_OFF: assert property (!enabled_o && m_valid_i[0] |=> s_valid_o[0])
      else $error("disabled checker blocked a transfer");
   AST_FWD: assert property (s_fwd |->
      s_addr_o[0] == $past(m_addr_i[0]) && s_write_o[0] == $past(m_write_i[0]))
      else $error("forwarded attributes differ");
   AST_REC: assert property (s_bad |-> err_flag_o[0] &&
      err_record_o[0][63:32] == $past(m_addr_i[0]) && err_record_o[0][6:0] ==
      {$past(m_master_i[0]), $past(m_super_i[0]), $past(m_exec_i[0]), $past(m_write_i[0])})
      else $error("fault record wrong");
   // a fault in the clear cycle wins, hence the escape
   AST_CLR: assert property (err_clear_i[0] |=> !err_flag_o[0] || m_err_o[0])
      else $error("flag not cleared");
   AST_HOLD: assert property (err_flag_o[0] && !err_clear_i[0] |=> err_flag_o[0])
      else $error("flag lost");
endmodule
bind region_access_checker rac_props i_rac_props (.*);
`default_nettype wire

/* verification/guarded_slave_model.sv */
// memory port slave stand-in counting transfers that reach it
`default_nettype none
module guarded_slave_model (
   input wire logic clk_i, // clock
   input wire logic reset_i, // reset
   input wire logic valid_i, // forwarded pulse
   output var int count_o // transfers seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // blocked cycles must never show up here
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) count_o <= 0;
      else if (valid_i) count_o <= count_o + 1;
   end
endmodule
`default_nettype wire

/* verification/region_access_checker_tb_top.sv */
// self-checking bench for the region access checker
`default_nettype none
module region_access_checker_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 0, reset_i = 1, enable_wr_i = 0, enable_i = 0, cfg_wr_i = 0;
   logic [3:0] cfg_region_i = '0;
   logic [2:0] cfg_sel_i = '0;
   logic [31:0] cfg_data_i = '0;
   logic [1:0] m_valid_i = '0, m_write_i = '0, m_exec_i = '0, m_super_i = '0;
   logic [1:0] err_clear_i = '0;
   logic [1:0][31:0] m_addr_i = '0;
   logic [1:0][3:0] m_master_i = '0;
   logic [1:0] m_err_o, s_valid_o, s_write_o, err_flag_o;
   logic [1:0][31:0] s_addr_o;
   logic [1:0][63:0] err_record_o;
   logic enabled_o;
   int n_errors = 0, tests_run = 0, cyc = 0, n_fwd = 0, slave_cnt;
   region_access_checker i_region_access_checker (.*);
   guarded_slave_model i_guarded_slave_model (.clk_i(ref_clk_i), .reset_i(reset_i),
      .valid_i(s_valid_o[0]), .count_o(slave_cnt));
   // clock and hang guard, ceiling far above the fewer than a hundred cycles used
   initial forever #4 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic check(input string what, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cfg(input logic [3:0] r, input logic [2:0] s, input logic [31:0] d);
      @(posedge ref_clk_i) #1;
      {cfg_wr_i, cfg_region_i, cfg_sel_i, cfg_data_i} = {1'b1, r, s, d};
      @(posedge ref_clk_i) #1;
      cfg_wr_i = 0;
   endtask
   task automatic region(input logic [3:0] r, input logic [31:0] lo, hi, acw);
      cfg(r, 3'h0, lo);
      cfg(r, 3'h1, hi);
      cfg(r, 3'h2, acw);
      cfg(r, 3'h3, 32'h1);
   endtask
   task automatic en(input logic v);
      @(posedge ref_clk_i) #1;
      {enable_wr_i, enable_i} = {1'b1, v};
      @(posedge ref_clk_i) #1;
      enable_wr_i = 0;
      check("enable", enabled_o, v);
   endtask
   // swx packs supervisor, fetch and write
   task automatic xfer(input int p, input logic [31:0] a, input logic [3:0] m,
         input logic [2:0] swx, input logic err);
      @(posedge ref_clk_i) #1;
      {m_valid_i[p], m_addr_i[p], m_master_i[p]} = {1'b1, a, m};
      {m_super_i[p], m_exec_i[p], m_write_i[p]} = swx;
      @(posedge ref_clk_i) #1;
      m_valid_i[p] = 0;
      check("error response", m_err_o[p], err);
      check("forwarded", s_valid_o[p], !err);
      if (err) check("fault address", err_record_o[p][63:32], a);
      if (!err) check("forwarded address", s_addr_o[p], a);
      if (!err) check("forwarded direction", s_write_o[p], swx[0]);
      if (!err && p == 0) n_fwd++;
   endtask
   task automatic t_grant();
      check("enabled after reset", enabled_o, 1'b0);
      xfer(1, 32'hffff_ffe0, 4'h7, 3'b011, 0);
      region(2, 32'h1000_0000, 32'h1000_0000, 12'h001);
      en(1);
      xfer(0, 32'h1000_001f, 4'h0, 3'b100, 0);
      xfer(0, 32'h1000_0020, 4'h0, 3'b100, 1);
      xfer(0, 32'h1000_0000, 4'h0, 3'b101, 1);
      xfer(0, 32'h1000_0004, 4'h0, 3'b000, 1);
      xfer(1, 32'h0000_0040, 4'h2, 3'b001, 1);
      check("no hit record", err_record_o[1], {32'h40, 25'h0, 7'h11});
      check("flags", err_flag_o, 2'b11);
      $display("test grant done");
   endtask
   task automatic t_masters();
      for (int m = 1; m < 4; m++) begin
         cfg(2, 3'h4, 32'h1 << (6 + 2 * (m - 1)));
         xfer(m % 2, 32'h1000_0008, m[3:0], 3'b000, 0);
         xfer(m % 2, 32'h1000_0008, m[3:0], 3'b001, 1);
      end
      xfer(0, 32'h1000_0008, 4'h4, 3'b000, 1);
      cfg(2, 3'h4, 32'h4);
      xfer(0, 32'h1000_0008, 4'h0, 3'b110, 0);
      xfer(0, 32'h1000_0008, 4'h0, 3'b100, 1);
      $display("test masters done");
   endtask
   task automatic t_overlap();
      cfg(2, 3'h4, 32'h1);
      region(3, 32'h1000_0000, 32'h1000_ffe0, 12'h002);
      xfer(0, 32'h1000_0010, 4'h0, 3'b101, 0);
      xfer(0, 32'h1000_0010, 4'h0, 3'b100, 0);
      xfer(0, 32'h1000_0010, 4'h0, 3'b000, 1);
      check("hit map", err_record_o[0][31:16], 16'h000c);
      cfg(3, 3'h0, 32'h1000_0000);
      xfer(0, 32'h1000_0010, 4'h0, 3'b101, 1);
      cfg(3, 3'h3, 32'h1);
      xfer(0, 32'h1000_0010, 4'h0, 3'b101, 0);
      // last descriptor, last granule of the address space
      region(15, 32'hffff_ffe0, 32'hffff_ffe0, 12'h008);
      xfer(0, 32'hffff_fffc, 4'h0, 3'b000, 0);
      $display("test overlap done");
   endtask
   task automatic t_clear();
      @(posedge ref_clk_i) #1;
      err_clear_i = 2'b11;
      @(posedge ref_clk_i) #1;
      err_clear_i = 2'b00;
      check("flags cleared", err_flag_o, 2'b00);
      en(0);
      xfer(0, 32'h0000_0040, 4'h5, 3'b001, 0);
      // the slave counts the last forward one edge after it leaves the checker
      @(posedge ref_clk_i) #1;
      check("slave count", slave_cnt, n_fwd);
      $display("test clear done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // reset for four cycles, then the scenarios in order
   initial begin
      repeat (4) @(posedge ref_clk_i);
      #1 reset_i = 0;
      t_grant();
      t_masters();
      t_overlap();
      t_clear();
      final_report();
   end
endmodule
`default_nettype wire
